// ==== verification/cad_data_regs_props.sv ====
// Assertions on the counter array register data path.
`timescale 1ns/1ps
module cad_data_regs_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        count_en,
  input wire logic        watchdog_enable_bit,
  input wire logic        reload_select,
  input wire logic [15:0] count,
  input wire logic [2:0]  compare_enable,
  input wire logic [2:0]  match,
  input wire logic [47:0] reload_value,
  input wire logic [47:0] capture_compare_value
);
  logic [7:0] snap;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Shadow of the snapshot, loaded by every read of the lower counter byte.
  always @(posedge clk) begin
    if (rst)
      snap <= 8'h00;
    else if (sfr_rd && sfr_addr == 8'hF9)
      snap <= count[15:8];
  end
  a_lo_clear: assert property (sfr_wr && sfr_addr == 8'hE9 |=> !compare_enable[1])
    else $error("low capture write left compare on");
  a_hi_set: assert property (sfr_wr && sfr_addr == 8'hEC |=> compare_enable[2])
    else $error("high capture write left compare off");
  a_lock_hold: assert property (sfr_wr && (sfr_addr == 8'hF9 || sfr_addr == 8'hFA)
    && watchdog_enable_bit && !count_en |=> count == $past(count))
    else $error("locked counter changed");
  a_hi_write: assert property (sfr_wr && sfr_addr == 8'hFA && !watchdog_enable_bit
    |=> count[15:8] == $past(sfr_wdata))
    else $error("counter high byte not written");
  a_cap_write: assert property (sfr_wr && sfr_addr == 8'hFB && !reload_select
    |=> capture_compare_value[7:0] == $past(sfr_wdata))
    else $error("capture low byte not written");
  a_reload_write: assert property (sfr_wr && sfr_addr == 8'hFC && reload_select
    |=> reload_value[15:8] == $past(sfr_wdata))
    else $error("reload high byte not written");
  a_snap_read: assert property (sfr_rd && sfr_addr == 8'hFA |=> sfr_rdata == $past(snap))
    else $error("high byte read not the snapshot");
  a_lo_read: assert property (sfr_rd && sfr_addr == 8'hF9 |=> sfr_rdata == $past(count[7:0]))
    else $error("low byte read wrong");
  a_cmp_gate: assert property (!compare_enable[0] |=> !match[0])
    else $error("match without compare enable");
  a_match_hit: assert property (compare_enable[0] && count == capture_compare_value[15:0]
    |=> match[0])
    else $error("enabled compare missed a match");
endmodule
bind cad_data_regs cad_data_regs_props u_props (
  .clk                   (clk),
  .rst                   (rst),
  .sfr_addr              (sfr_addr),
  .sfr_wdata             (sfr_wdata),
  .sfr_wr                (sfr_wr),
  .sfr_rd                (sfr_rd),
  .sfr_rdata             (sfr_rdata),
  .count_en              (count_en),
  .watchdog_enable_bit   (watchdog_enable_bit),
  .reload_select         (reload_select),
  .count                 (count),
  .compare_enable        (compare_enable),
  .match                 (match),
  .reload_value          (reload_value),
  .capture_compare_value (capture_compare_value)
);

// ==== verification/tb_cad_data_regs.sv ====
// Self-checking bench for the counter array register data path.
`timescale 1ns/1ps
module tb_cad_data_regs;
  logic        clk, rst, sfr_wr, sfr_rd, count_en, wdt, rsel;
  logic [7:0]  addr, wdata, rdata;
  logic [15:0] count;
  logic [2:0]  cen, match;
  logic [47:0] ccv, rlv;
  logic [2:0]  mode_wr;
  logic [7:0]  mode_wdata;
  int          errors, checked, cyc;
  cad_data_regs dut (.clk(clk), .rst(rst), .sfr_addr(addr), .sfr_wdata(wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(rdata), .count_en(count_en), .watchdog_enable_bit(wdt),
    .reload_select(rsel), .mode_wr(mode_wr), .mode_wdata(mode_wdata), .count(count),
    .compare_enable(cen), .match(match), .capture_compare_value(ccv), .reload_value(rlv));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // The whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      close_out;
    end
  end
  task automatic close_out;
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    #1;
  endtask
  task automatic mode(input logic [2:0] m, input logic [7:0] d);
    @(posedge clk);
    mode_wr <= m;
    mode_wdata <= d;
    @(posedge clk);
    mode_wr <= 3'h0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic t_capture;
    logic [7:0] a[6] = '{8'hFB, 8'hFC, 8'hE9, 8'hEA, 8'hEB, 8'hEC};
    logic [7:0] d;
    for (int i = 0; i < 6; i++) begin
      rd(a[i], d);
      chk("capture reset", 16'h0000, {8'h00, d});
      wr(a[i], 8'h50 + 8'(i));
      chk("compare enable", 16'(i % 2), {15'h0000, cen[i / 2]});
      rd(a[i], d);
      chk("capture byte", {8'h00, 8'h50 + 8'(i)}, {8'h00, d});
    end
    chk("value 0", 16'h5150, ccv[15:0]);
    chk("value 1", 16'h5352, ccv[31:16]);
    chk("value 2", 16'h5554, ccv[47:32]);
  endtask
  task automatic t_reload;
    logic [7:0] d;
    @(posedge clk);
    rsel <= 1'b1;
    wr(8'hEB, 8'h00);
    chk("enable in reload", 16'h0000, {15'h0000, cen[2]});
    wr(8'hFC, 8'hA5);
    rd(8'hFC, d);
    chk("reload byte", 16'h00A5, {8'h00, d});
    chk("reload out", 16'hA500, rlv[15:0]);
    @(posedge clk);
    rsel <= 1'b0;
    rd(8'hFC, d);
    chk("capture kept", 16'h0051, {8'h00, d});
  endtask
  task automatic t_counter;
    logic [7:0] d;
    @(posedge clk);
    wdt <= 1'b1;
    wr(8'hFA, 8'h12);
    wr(8'hF9, 8'h34);
    chk("locked count", 16'h0000, count);
    @(posedge clk);
    wdt <= 1'b0;
    wr(8'hFA, 8'h12);
    wr(8'hF9, 8'hF0);
    rd(8'hF9, d);
    chk("low byte", 16'h00F0, {8'h00, d});
    @(posedge clk);
    count_en <= 1'b1;
    repeat (40) @(posedge clk);
    count_en <= 1'b0;
    rd(8'hFA, d);
    chk("stale snapshot", 16'h0012, {8'h00, d});
    rd(8'hF9, d);
    rd(8'hFA, d);
    chk("fresh snapshot", 16'h0013, {8'h00, d});
    chk("counted past", 16'h0013, {8'h00, count[15:8]});
    rd(8'h00, d);
    chk("unmapped", 16'h0000, {8'h00, d});
  endtask
  task automatic t_match;
    wr(8'hFA, 8'h51);
    wr(8'hF9, 8'h50);
    mode(3'h1, 8'h00);
    chk("mode clear", 16'h0000, {15'h0000, cen[0]});
    @(posedge clk);
    #1;
    chk("gated match", 16'h0000, {13'h0000, match});
    mode(3'h1, 8'h40);
    chk("mode set", 16'h0001, {15'h0000, cen[0]});
    @(posedge clk);
    #1;
    chk("match", 16'h0001, {13'h0000, match});
  endtask
  initial begin
    rst <= 1'b1;
    {sfr_wr, sfr_rd, count_en, wdt, rsel} <= 5'h00;
    {addr, wdata} <= 16'h0000;
    {mode_wr, mode_wdata} <= 11'h000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_capture;
    t_reload;
    t_counter;
    t_match;
    close_out;
  end
endmodule

// ==== verilog/cad_counter.v ====
// Free-running 16-bit counter with byte writes, watchdog lock and high-byte snapshot.
`timescale 1ns/1ps
`include "cad_regs.vh"
module cad_counter (
  input  wire        clk,
  input  wire        rst,
  input  wire        count_en,
  input  wire        wdt_en,
  input  wire        wr_lo,
  input  wire        wr_hi,
  input  wire        rd_lo,
  input  wire [7:0]  wdata,
  output reg  [15:0] count,
  output reg  [7:0]  snap_hi
);
  always @(posedge clk) begin
    if (rst) begin
      count   <= `CAD_RST_WORD;
      snap_hi <= `CAD_RST_BYTE;
    end else begin
      if (wr_lo && !wdt_en) begin
        count <= {count[15:8], wdata};
      end else if (wr_hi && !wdt_en) begin
        count <= {wdata, count[7:0]};
      end else if (count_en) begin
        count <= count + 16'h0001;
      end
      if (rd_lo) begin
        snap_hi <= count[15:8];
      end
    end
  end
endmodule

// ==== verilog/cad_data_regs.v ====
// Special function register data path of the counter array.
`timescale 1ns/1ps
`include "cad_regs.vh"
module cad_data_regs (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  sfr_addr,
  input  wire [7:0]  sfr_wdata,
  input  wire        sfr_wr,
  input  wire        sfr_rd,
  output reg  [7:0]  sfr_rdata,
  input  wire        count_en,
  input  wire        watchdog_enable_bit,
  input  wire        reload_select,
  input  wire [2:0]  mode_wr,
  input  wire [7:0]  mode_wdata,
  output wire [15:0] count,
  output wire [2:0]  compare_enable,
  output wire [2:0]  match,
  output wire [47:0] capture_compare_value,
  output wire [47:0] reload_value
);
  wire [7:0] snap_hi;
  wire       wr_cnt_lo = sfr_wr && (sfr_addr == `CAD_ADDR_CNT_LO);
  wire       wr_cnt_hi = sfr_wr && (sfr_addr == `CAD_ADDR_CNT_HI);
  wire       rd_cnt_lo = sfr_rd && (sfr_addr == `CAD_ADDR_CNT_LO);

  function [1:0] lo_index;
    input [7:0] a;
    begin
      case (a)
        `CAD_ADDR_CAP_LO0: lo_index = 2'd0;
        `CAD_ADDR_CAP_LO1: lo_index = 2'd1;
        `CAD_ADDR_CAP_LO2: lo_index = 2'd2;
        default:           lo_index = 2'd3;
      endcase
    end
  endfunction

  function [1:0] hi_index;
    input [7:0] a;
    begin
      case (a)
        `CAD_ADDR_CAP_HI0: hi_index = 2'd0;
        `CAD_ADDR_CAP_HI1: hi_index = 2'd1;
        `CAD_ADDR_CAP_HI2: hi_index = 2'd2;
        default:           hi_index = 2'd3;
      endcase
    end
  endfunction

  cad_counter u_counter (
    .clk      (clk),
    .rst      (rst),
    .count_en (count_en),
    .wdt_en   (watchdog_enable_bit),
    .wr_lo    (wr_cnt_lo),
    .wr_hi    (wr_cnt_hi),
    .rd_lo    (rd_cnt_lo),
    .wdata    (sfr_wdata),
    .count    (count),
    .snap_hi  (snap_hi)
  );

  // Turns a module index into one strobe per module; index 3 selects no module.
  function [2:0] one_hot;
    input [1:0] idx;
    begin
      case (idx)
        2'h0:    one_hot = 3'h1;
        2'h1:    one_hot = 3'h2;
        2'h2:    one_hot = 3'h4;
        default: one_hot = 3'h0;
      endcase
    end
  endfunction

  // Capture byte write strobes, one bit per module.
  wire [1:0]  lo_sel = lo_index(sfr_addr);
  wire [1:0]  hi_sel = hi_index(sfr_addr);
  wire [2:0]  wr_cap_lo;
  wire [2:0]  wr_cap_hi;
  assign wr_cap_lo = sfr_wr ? one_hot(lo_sel) : 3'h0;
  assign wr_cap_hi = sfr_wr ? one_hot(hi_sel) : 3'h0;

  wire [15:0] cap_value0;
  wire [15:0] cap_value1;
  wire [15:0] cap_value2;
  wire [15:0] rel_value0;
  wire [15:0] rel_value1;
  wire [15:0] rel_value2;
  assign capture_compare_value = {cap_value2, cap_value1, cap_value0};
  assign reload_value          = {rel_value2, rel_value1, rel_value0};

  // All modules share the write data and the counter; only the strobes differ.
  cad_module u_mod0 (
    .clk                   (clk),
    .rst                   (rst),
    .reload_select         (reload_select),
    .wr_lo                 (wr_cap_lo[0]),
    .wr_hi                 (wr_cap_hi[0]),
    .wdata                 (sfr_wdata),
    .cfg_wr                (mode_wr[0]),
    .cfg_cmp_en            (mode_wdata[`CAD_MODE_CMP_EN_BIT]),
    .count                 (count),
    .capture_compare_value (cap_value0),
    .reload_value          (rel_value0),
    .compare_enable        (compare_enable[0]),
    .match                 (match[0])
  );

  cad_module u_mod1 (
    .clk                   (clk),
    .rst                   (rst),
    .reload_select         (reload_select),
    .wr_lo                 (wr_cap_lo[1]),
    .wr_hi                 (wr_cap_hi[1]),
    .wdata                 (sfr_wdata),
    .cfg_wr                (mode_wr[1]),
    .cfg_cmp_en            (mode_wdata[`CAD_MODE_CMP_EN_BIT]),
    .count                 (count),
    .capture_compare_value (cap_value1),
    .reload_value          (rel_value1),
    .compare_enable        (compare_enable[1]),
    .match                 (match[1])
  );

  cad_module u_mod2 (
    .clk                   (clk),
    .rst                   (rst),
    .reload_select         (reload_select),
    .wr_lo                 (wr_cap_lo[2]),
    .wr_hi                 (wr_cap_hi[2]),
    .wdata                 (sfr_wdata),
    .cfg_wr                (mode_wr[2]),
    .cfg_cmp_en            (mode_wdata[`CAD_MODE_CMP_EN_BIT]),
    .count                 (count),
    .capture_compare_value (cap_value2),
    .reload_value          (rel_value2),
    .compare_enable        (compare_enable[2]),
    .match                 (match[2])
  );

  // One select bit steers every capture address at once, so software must set
  // it before the byte accesses that it means to reach the reload values.
  reg  [7:0]  next_rdata;
  always @* begin
    next_rdata = `CAD_RST_BYTE;
    case (sfr_addr)
      `CAD_ADDR_CNT_LO: begin
        next_rdata = count[7:0];
      end
      `CAD_ADDR_CNT_HI: begin
        next_rdata = snap_hi;
      end
      `CAD_ADDR_CAP_LO0: begin
        if (reload_select) begin
          next_rdata = rel_value0[7:0];
        end else begin
          next_rdata = cap_value0[7:0];
        end
      end
      `CAD_ADDR_CAP_HI0: begin
        if (reload_select) begin
          next_rdata = rel_value0[15:8];
        end else begin
          next_rdata = cap_value0[15:8];
        end
      end
      `CAD_ADDR_CAP_LO1: begin
        if (reload_select) begin
          next_rdata = rel_value1[7:0];
        end else begin
          next_rdata = cap_value1[7:0];
        end
      end
      `CAD_ADDR_CAP_HI1: begin
        if (reload_select) begin
          next_rdata = rel_value1[15:8];
        end else begin
          next_rdata = cap_value1[15:8];
        end
      end
      `CAD_ADDR_CAP_LO2: begin
        if (reload_select) begin
          next_rdata = rel_value2[7:0];
        end else begin
          next_rdata = cap_value2[7:0];
        end
      end
      `CAD_ADDR_CAP_HI2: begin
        if (reload_select) begin
          next_rdata = rel_value2[15:8];
        end else begin
          next_rdata = cap_value2[15:8];
        end
      end
      default: begin
        next_rdata = `CAD_RST_BYTE;
      end
    endcase
  end

  // Read data is registered and holds until the next read; unmapped reads give zero.
  always @(posedge clk) begin
    if (rst) begin
      sfr_rdata <= `CAD_RST_BYTE;
    end else if (sfr_rd) begin
      sfr_rdata <= next_rdata;
    end
  end
endmodule

// ==== verilog/cad_module.v ====
// One capture/compare module: value, auto-reload value and compare enable bit.
`timescale 1ns/1ps
`include "cad_regs.vh"
module cad_module (
  input  wire        clk,
  input  wire        rst,
  input  wire        reload_select,
  input  wire        wr_lo,
  input  wire        wr_hi,
  input  wire [7:0]  wdata,
  input  wire        cfg_wr,
  input  wire        cfg_cmp_en,
  input  wire [15:0] count,
  output reg  [15:0] capture_compare_value,
  output reg  [15:0] reload_value,
  output reg         compare_enable,
  output reg         match
);
  always @(posedge clk) begin
    if (rst) begin
      capture_compare_value <= `CAD_RST_WORD;
      reload_value          <= `CAD_RST_WORD;
      compare_enable        <= 1'b0;
      match                 <= 1'b0;
    end else begin
      if (wr_lo) begin
        if (reload_select) begin
          reload_value[7:0] <= wdata;
        end else begin
          capture_compare_value[7:0] <= wdata;
        end
      end
      if (wr_hi) begin
        if (reload_select) begin
          reload_value[15:8] <= wdata;
        end else begin
          capture_compare_value[15:8] <= wdata;
        end
      end
      // Byte writes win over a mode register write in the same cycle.
      if (wr_lo) begin
        compare_enable <= 1'b0;
      end else if (wr_hi) begin
        compare_enable <= 1'b1;
      end else if (cfg_wr) begin
        compare_enable <= cfg_cmp_en;
      end
      match <= compare_enable && (count == capture_compare_value);
    end
  end
endmodule

// ==== verilog/cad_regs.vh ====
// Register addresses, field positions and reset values of the counter array data path.
`ifndef CAD_REGS_VH
`define CAD_REGS_VH
`define CAD_ADDR_CNT_LO     8'hF9
`define CAD_ADDR_CNT_HI     8'hFA
`define CAD_ADDR_CAP_LO0    8'hFB
`define CAD_ADDR_CAP_HI0    8'hFC
`define CAD_ADDR_CAP_LO1    8'hE9
`define CAD_ADDR_CAP_HI1    8'hEA
`define CAD_ADDR_CAP_LO2    8'hEB
`define CAD_ADDR_CAP_HI2    8'hEC
`define CAD_RST_BYTE        8'h00
`define CAD_RST_WORD        16'h0000
`define CAD_MODE_CMP_EN_BIT 6
`define CAD_NUM_MODULES     3
`endif
